// [rtl/aoc_channel.sv]
// analog output channel behaviour with four input alarm channels
//
// Contract
// - A high process alarm stays set until the input drops below the limit by more than the hysteresis.
// - Four input channels 0 to 3 each have their own limit and hysteresis.
// - With init hold, after connect, idle-to-run or fault recovery the output holds until a request is within 0.1% of full scale.
// - The alarm mask bit at 1 suppresses every output alarm, at 0 leaves them active.
// - With sticky slew alarms a slew alarm stays set until software clears it.
// - With sticky clamp alarms a clamp alarm stays set until software clears it.
// - On communication loss the output holds when the select bit is 0 and goes to the loss value when 1.
// - On entering idle the output holds when the select bit is 0 and goes to the idle value when 1.
// - With run slewing the output moves toward each request no faster than the slew rate limit; a step that rounds to zero still moves one code per update.
// - With idle slewing the output moves toward the idle value no faster than the slew rate limit; a step that rounds to zero still moves one code per update.
// - With loss slewing the output moves toward the loss value no faster than the slew rate limit; a step that rounds to zero still moves one code per update.
// - Range code 0 selects the bipolar voltage range and code 1 the current range.
// - The slew rate limit is an integer in percent of full scale per second, used only where slewing is on.
// - A high process alarm sets when the input rises above its high limit.
// - A request below the floor sets the low clamp alarm and the output stays at the floor.
`timescale 1ns/100ps
`default_nettype none
`include "aoc_consts.svh"

module aoc_channel #(
  parameter int N_IN = 4,
  parameter int UPDATE_NS = `AOC_UPDATE_NS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic comm_ok,
  input wire logic run_mode,
  input wire aoc_pkg::aoc_out_cfg_t out_cfg,
  input wire logic signed [15:0] requested_value,
  input wire logic alarm_clear,
  input wire aoc_pkg::aoc_in_cfg_t [N_IN-1:0] in_cfg,
  input wire logic signed [15:0] in_value [N_IN],
  output logic signed [15:0] out_value_q,
  output logic [1:0] out_range_q,
  output aoc_pkg::aoc_alarm_t out_alarm_q,
  output aoc_pkg::aoc_state_t state_q,
  output logic [N_IN-1:0] high_process_alarm_q
);

  // ----------------------------------------------------------------
  // update period and slew step
  // ----------------------------------------------------------------
  localparam int UPDATE_CYC = (UPDATE_NS / `AOC_CLK_PERIOD_NS < 1) ? 1 :
                              UPDATE_NS / `AOC_CLK_PERIOD_NS;
  localparam logic [31:0] TICK_LAST = 32'(UPDATE_CYC - 1);
  localparam logic [63:0] HOLD_TOL64 =
    `AOC_FULL_SCALE * `AOC_HOLD_TOL_PER_MILLE / `AOC_PER_MILLE;
  localparam logic [16:0] HOLD_TOL = HOLD_TOL64[16:0];

  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  logic [63:0] step64;
  logic [16:0] step;

  // update tick counter
  always_comb begin
    tick = (tick_cnt_q == TICK_LAST);
    tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + `AOC_TICK_ONE;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // step per update from percent of full scale per second
  always_comb begin
    step64 = `AOC_FULL_SCALE * 64'(out_cfg.slew_rate_limit) *
             64'(UPDATE_NS) / (`AOC_PERCENT * `AOC_NS_PER_S);
    if (step64 > 64'(`AOC_STEP_MAX)) begin
      step = `AOC_STEP_MAX;
    end else if (step64 == 64'h0) begin
      step = `AOC_STEP_MIN; // a zero result still crawls forward
    end else begin
      step = step64[16:0];
    end
  end

  // ----------------------------------------------------------------
  // output behaviour
  // ----------------------------------------------------------------
  aoc_pkg::aoc_state_t state_d;
  logic signed [15:0] floor_eff, req_clamped, target, out_value_d;
  logic signed [16:0] diff, hold_diff;
  logic slew_on, limiting, req_low, req_high, near_req;
  aoc_pkg::aoc_alarm_t raw_alarm, out_alarm_d;
  logic [1:0] out_range_d;

  // range dependent floor and request clamping
  always_comb begin
    floor_eff = out_cfg.output_floor;
    if (out_cfg.range_code == `AOC_RANGE_CURRENT &&
        out_cfg.output_floor < $signed(`AOC_ZERO_VALUE)) begin
      floor_eff = $signed(`AOC_ZERO_VALUE);
    end
    req_low = requested_value < floor_eff;
    req_high = requested_value > out_cfg.output_ceiling;
    if (req_low) begin
      req_clamped = floor_eff;
    end else if (req_high) begin
      req_clamped = out_cfg.output_ceiling;
    end else begin
      req_clamped = requested_value;
    end
    hold_diff = 17'(requested_value) - 17'(out_value_q);
    near_req = (hold_diff < 0 ? -hold_diff : hold_diff) <= $signed(HOLD_TOL);
  end

  // mode sequencing, fault before idle before run
  always_comb begin
    state_d = state_q;
    if (!comm_ok) begin
      state_d = aoc_pkg::AOC_ST_FAULT;
    end else if (!run_mode) begin
      state_d = aoc_pkg::AOC_ST_IDLE;
    end else begin
      case (state_q)
        aoc_pkg::AOC_ST_INIT, aoc_pkg::AOC_ST_IDLE,
        aoc_pkg::AOC_ST_FAULT: begin
          state_d = out_cfg.init_hold_enable ? aoc_pkg::AOC_ST_HOLD :
                    aoc_pkg::AOC_ST_RUN;
        end
        aoc_pkg::AOC_ST_HOLD: begin
          if (near_req) begin
            state_d = aoc_pkg::AOC_ST_RUN;
          end
        end
        aoc_pkg::AOC_ST_RUN: state_d = aoc_pkg::AOC_ST_RUN;
        default: state_d = aoc_pkg::AOC_ST_INIT;
      endcase
    end
  end

  // target selection and slew limiting
  always_comb begin
    target = out_value_q;
    slew_on = 1'b0;
    case (state_q)
      aoc_pkg::AOC_ST_RUN: begin
        target = req_clamped;
        slew_on = out_cfg.run_slew_enable;
      end
      aoc_pkg::AOC_ST_IDLE: begin
        if (out_cfg.idle_behavior_select) begin
          target = out_cfg.idle_output_value;
        end
        slew_on = out_cfg.idle_slew_enable;
      end
      aoc_pkg::AOC_ST_FAULT: begin
        if (out_cfg.comm_loss_behavior_select) begin
          target = out_cfg.comm_loss_output_value;
        end
        slew_on = out_cfg.comm_loss_slew_enable;
      end
      default: target = out_value_q; // init and hold keep the level
    endcase
    diff = 17'(target) - 17'(out_value_q);
    limiting = slew_on && ((diff < 0 ? -diff : diff) > $signed(step));
    out_value_d = out_value_q;
    if (!slew_on) begin
      out_value_d = target;
    end else if (tick) begin
      if (!limiting) begin
        out_value_d = target;
      end else if (diff < 0) begin
        out_value_d = 16'(17'(out_value_q) - step);
      end else begin
        out_value_d = 16'(17'(out_value_q) + step);
      end
    end
    out_range_d = out_cfg.range_code;
  end

  // alarms: masked at the source, sticky until cleared with cause gone
  always_comb begin
    raw_alarm.slew = limiting && state_q == aoc_pkg::AOC_ST_RUN;
    raw_alarm.clamp_low = req_low && state_q == aoc_pkg::AOC_ST_RUN;
    raw_alarm.clamp_high = req_high && state_q == aoc_pkg::AOC_ST_RUN;
    if (out_cfg.alarm_mask_all) begin
      raw_alarm = '0;
    end
    out_alarm_d.slew = raw_alarm.slew ||
      (out_cfg.slew_alarm_sticky && out_alarm_q.slew && !alarm_clear &&
       !out_cfg.alarm_mask_all);
    out_alarm_d.clamp_low = raw_alarm.clamp_low ||
      (out_cfg.clamp_alarm_sticky && out_alarm_q.clamp_low &&
       !alarm_clear && !out_cfg.alarm_mask_all);
    out_alarm_d.clamp_high = raw_alarm.clamp_high ||
      (out_cfg.clamp_alarm_sticky && out_alarm_q.clamp_high &&
       !alarm_clear && !out_cfg.alarm_mask_all);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= aoc_pkg::AOC_ST_INIT;
      out_value_q <= `AOC_ZERO_VALUE;
      out_range_q <= `AOC_RANGE_VOLT;
      out_alarm_q <= '0;
    end else begin
      state_q <= state_d;
      out_value_q <= out_value_d;
      out_range_q <= out_range_d;
      out_alarm_q <= out_alarm_d;
    end
  end

  // ----------------------------------------------------------------
  // input process alarms with hysteresis
  // ----------------------------------------------------------------
  logic [N_IN-1:0] high_process_alarm_d;

  // one identical, independent alarm per input channel
  for (genvar i = 0; i < N_IN; i++) begin : g_in
    logic signed [17:0] back_level;
    always_comb begin
      back_level = 18'(in_value[i]) + 18'({2'b00, in_cfg[i].alarm_hysteresis});
      if (in_value[i] > in_cfg[i].high_limit) begin
        high_process_alarm_d[i] = 1'b1;
      end else if (back_level < 18'(in_cfg[i].high_limit)) begin
        high_process_alarm_d[i] = 1'b0;
      end else begin
        high_process_alarm_d[i] = high_process_alarm_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      high_process_alarm_q <= '0;
    end else begin
      high_process_alarm_q <= high_process_alarm_d;
    end
  end

endmodule : aoc_channel
`default_nettype wire

// [rtl/aoc_consts.svh]
// constants of the analog output channel behaviour block
`ifndef AOC_CONSTS_SVH
`define AOC_CONSTS_SVH
`define AOC_FULL_SCALE 64'h0000_0000_0001_0000
`define AOC_HOLD_TOL_PER_MILLE 64'h0000_0000_0000_0001
`define AOC_PER_MILLE 64'h0000_0000_0000_03E8
`define AOC_PERCENT 64'h0000_0000_0000_0064
`define AOC_NS_PER_S 64'h0000_0000_3B9A_CA00
`define AOC_CLK_PERIOD_NS 4
`define AOC_UPDATE_NS 1000000
`define AOC_STEP_MAX 17'h0FFFF
`define AOC_STEP_MIN 17'h00001
`define AOC_RANGE_VOLT 2'h0
`define AOC_RANGE_CURRENT 2'h1
`define AOC_ZERO_VALUE 16'h0000
`define AOC_TICK_ONE 32'h0000_0001
`endif

// [rtl/aoc_pkg.sv]
// types of the analog output channel behaviour block
package aoc_pkg;
  // output channel configuration
  typedef struct packed {
    logic init_hold_enable;
    logic alarm_mask_all;
    logic slew_alarm_sticky;
    logic clamp_alarm_sticky;
    logic comm_loss_behavior_select;
    logic idle_behavior_select;
    logic run_slew_enable;
    logic idle_slew_enable;
    logic comm_loss_slew_enable;
    logic [1:0] range_code;
    logic [15:0] slew_rate_limit;
    logic signed [15:0] comm_loss_output_value;
    logic signed [15:0] idle_output_value;
    logic signed [15:0] output_floor;
    logic signed [15:0] output_ceiling;
  } aoc_out_cfg_t;

  // input channel alarm configuration
  typedef struct packed {
    logic signed [15:0] high_limit;
    logic [15:0] alarm_hysteresis;
  } aoc_in_cfg_t;

  // output channel alarms
  typedef struct packed {
    logic slew;
    logic clamp_low;
    logic clamp_high;
  } aoc_alarm_t;

  // output behaviour state
  typedef enum logic [2:0] {
    AOC_ST_INIT = 3'b000,
    AOC_ST_HOLD = 3'b001,
    AOC_ST_RUN = 3'b010,
    AOC_ST_IDLE = 3'b011,
    AOC_ST_FAULT = 3'b100
  } aoc_state_t;
endpackage : aoc_pkg

// [verif/aoc_channel_test.sv]
// self-checking bench for the output channel behaviour block
`timescale 1ns/100ps
`default_nettype none
module aoc_channel_test;
  logic clk_sys, rst_b, comm_ok, run_mode, alarm_clear;
  logic signed [15:0] req, out_value_q;
  logic signed [15:0] in_value [4];
  logic [1:0] out_range_q;
  logic [3:0] hpa_q;
  aoc_pkg::aoc_out_cfg_t cfg;
  aoc_pkg::aoc_in_cfg_t [3:0] in_cfg;
  aoc_pkg::aoc_alarm_t alarm_q;
  aoc_pkg::aoc_state_t state_q;
  int failures, n_checks;
  aoc_ctrl_model u_ctl (.clk_sys(clk_sys), .comm_ok(comm_ok),
    .run_mode(run_mode), .requested_value(req), .alarm_clear(alarm_clear));
  aoc_channel #(.UPDATE_NS(40)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .comm_ok(comm_ok), .run_mode(run_mode), .out_cfg(cfg),
    .requested_value(req), .alarm_clear(alarm_clear), .in_cfg(in_cfg),
    .in_value(in_value), .out_value_q(out_value_q),
    .out_range_q(out_range_q), .out_alarm_q(alarm_q), .state_q(state_q),
    .high_process_alarm_q(hpa_q));
  // 4 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic go(input logic ok, run, input logic [15:0] v);
    u_ctl.send(ok, run, v, 1'b0);
    cyc(3);
  endtask : go
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // floor clamp, sticky alarm, clear, current range, mask
  task automatic s_clamp();
    cfg.clamp_alarm_sticky = 1'b1;
    go(1'b1, 1'b1, 16'hFE00);
    chk(out_value_q, 16'hFF00);
    go(1'b1, 1'b1, 16'h0050);
    chk(alarm_q, 3'h2);
    u_ctl.send(1'b1, 1'b1, 16'h0050, 1'b1);
    go(1'b1, 1'b1, 16'h0050);
    chk(alarm_q, 3'h0);
    cfg.range_code = 2'h1;
    go(1'b1, 1'b1, 16'hFE00);
    chk(out_value_q, 16'h0000);
    chk(out_range_q, 2'h1);
    cfg.alarm_mask_all = 1'b1;
    cyc(2);
    chk(alarm_q, 3'h0);
    go(1'b1, 1'b1, 16'h0200);
    cfg = {9'h000, 2'h0, 16'h0000, cfg[63:0]};
  endtask : s_clamp
  // loss and idle with hold-last and go-to-value selections
  task automatic s_modes();
    for (int s = 0; s < 2; s++) begin
      cfg.comm_loss_behavior_select = s[0];
      cfg.idle_behavior_select = s[0];
      go(1'b1, 1'b1, 16'h0200);
      go(1'b0, 1'b1, 16'h0200);
      chk(out_value_q, s[0] ? 16'h1234 : 16'h0200);
      go(1'b1, 1'b1, 16'h0200);
      go(1'b1, 1'b0, 16'h0200);
      chk(out_value_q, s[0] ? 16'h0333 : 16'h0200);
    end
  endtask : s_modes
  // init hold from idle: 66 codes away refused, 65 accepted
  task automatic s_hold();
    cfg.init_hold_enable = 1'b1;
    go(1'b1, 1'b1, 16'h0600);
    go(1'b1, 1'b1, 16'h0375);
    chk(out_value_q, 16'h0333);
    go(1'b1, 1'b1, 16'h0374);
    chk(out_value_q, 16'h0374);
    cfg.init_hold_enable = 1'b0;
  endtask : s_hold
  // run slewing: one code per 10-cycle update, sticky slew alarm meanwhile;
  // then loss and idle slewing, 2 or 3 codes over 22 updating edges
  task automatic s_slew();
    int n;
    logic signed [15:0] v;
    cfg.run_slew_enable = 1'b1;
    cfg.slew_alarm_sticky = 1'b1;
    cfg.slew_rate_limit = 16'h0001;
    go(1'b1, 1'b1, 16'h037C);
    chk(alarm_q, 3'h4);
    n = 0;
    while (out_value_q !== 16'h037C && n < 200) begin
      cyc(1);
      n++;
    end
    chk(16'(n > 60 && n <= 80), 16'h0001);
    if (n == 200) test_done();
    chk(alarm_q, 3'h4);
    u_ctl.send(1'b1, 1'b1, 16'h037C, 1'b1);
    go(1'b1, 1'b1, 16'h037C);
    chk(alarm_q, 3'h0);
    cfg.comm_loss_slew_enable = 1'b1;
    go(1'b0, 1'b1, 16'h037C);
    cyc(20);
    v = out_value_q;
    chk(16'(v == 16'sh037E || v == 16'sh037F), 16'h0001);
    cfg.idle_slew_enable = 1'b1;
    go(1'b1, 1'b0, 16'h037C);
    cyc(20);
    chk(16'(out_value_q < v && out_value_q > v - 4), 16'h0001);
  endtask : s_slew
  // each input: set above limit, held in band, cleared below it
  task automatic s_inputs();
    for (int i = 0; i < 4; i++) begin
      in_value[i] = 16'h0101;
      cyc(2);
      chk(hpa_q, 16'(1 << i));
      in_value[i] = 16'h00F0;
      cyc(2);
      chk(hpa_q, 16'(1 << i));
      in_value[i] = 16'h00EF;
      cyc(2);
      chk(hpa_q, 16'h0000);
    end
  endtask : s_inputs
  // reset, then the scenarios
  initial begin
    rst_b = 1'b0;
    failures = 0;
    n_checks = 0;
    cfg = '0;
    cfg.output_floor = 16'hFF00;
    cfg.output_ceiling = 16'h7000;
    cfg.comm_loss_output_value = 16'h1234;
    cfg.idle_output_value = 16'h0333;
    for (int i = 0; i < 4; i++) begin
      in_cfg[i] = {16'h0100, 16'h0010};
      in_value[i] = 16'h0000;
    end
    cyc(2);
    rst_b = 1'b1;
    cyc(3);
    chk(state_q, aoc_pkg::AOC_ST_RUN);
    s_clamp();
    s_modes();
    s_hold();
    s_slew();
    s_inputs();
    test_done();
  end
endmodule : aoc_channel_test
`default_nettype wire

// [verif/aoc_ctrl_model.sv]
// owning controller model: link, mode, requested value and alarm clear
`timescale 1ns/100ps
`default_nettype none
module aoc_ctrl_model (
  input wire logic clk_sys,
  output var logic comm_ok,
  output var logic run_mode,
  output var logic signed [15:0] requested_value,
  output var logic alarm_clear
);
  // link up in run mode from time zero
  initial begin
    comm_ok = 1'b1;
    run_mode = 1'b1;
    requested_value = 16'h0000;
    alarm_clear = 1'b0;
  end
  // launch new levels just after an edge; clear lasts until the next send
  task automatic send(input logic ok, run, input logic [15:0] v, input logic c);
    @(posedge clk_sys);
    #1;
    comm_ok = ok;
    run_mode = run;
    requested_value = v;
    alarm_clear = c;
  endtask : send
endmodule : aoc_ctrl_model
`default_nettype wire

// [verif/aoc_props.sv]
// assertion checker for the output channel behaviour block
`timescale 1ns/100ps
`default_nettype none
module aoc_props #(
  parameter int N_IN = 4,
  parameter int UPDATE_NS = 1000000
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic comm_ok,
  input wire logic run_mode,
  input wire aoc_pkg::aoc_out_cfg_t out_cfg,
  input wire logic signed [15:0] requested_value,
  input wire logic alarm_clear,
  input wire aoc_pkg::aoc_in_cfg_t [N_IN-1:0] in_cfg,
  input wire logic signed [15:0] in_value [N_IN],
  input wire logic signed [15:0] out_value_q,
  input wire logic [1:0] out_range_q,
  input wire aoc_pkg::aoc_alarm_t out_alarm_q,
  input wire aoc_pkg::aoc_state_t state_q,
  input wire logic [N_IN-1:0] high_process_alarm_q
);
  // one clock domain, checks off while in reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // last input above its limit, or inside the hysteresis band
  wire logic in_over = in_value[N_IN-1] > in_cfg[N_IN-1].high_limit;
  wire logic in_band = int'(in_value[N_IN-1])
    + int'(in_cfg[N_IN-1].alarm_hysteresis) >= int'(in_cfg[N_IN-1].high_limit);
  wire logic in_run = state_q == aoc_pkg::AOC_ST_RUN;
  property p_fault; !comm_ok |=> state_q == aoc_pkg::AOC_ST_FAULT; endproperty
  a_fault: assert property (p_fault) else $error("no fault state");
  property p_loss; !comm_ok && state_q == aoc_pkg::AOC_ST_FAULT
    && out_cfg.comm_loss_behavior_select && !out_cfg.comm_loss_slew_enable
    |=> out_value_q == $past(out_cfg.comm_loss_output_value); endproperty
  a_loss: assert property (p_loss) else $error("bad loss value");
  property p_idle; comm_ok && !run_mode && state_q == aoc_pkg::AOC_ST_IDLE
    && out_cfg.idle_behavior_select && !out_cfg.idle_slew_enable
    |=> out_value_q == $past(out_cfg.idle_output_value); endproperty
  a_idle: assert property (p_idle) else $error("bad idle value");
  property p_mask; out_cfg.alarm_mask_all |=> out_alarm_q == 3'h0; endproperty
  a_mask: assert property (p_mask) else $error("masked alarm");
  property p_hold; state_q == aoc_pkg::AOC_ST_HOLD |=> $stable(out_value_q);
  endproperty
  a_hold: assert property (p_hold) else $error("hold moved");
  property p_in_set; in_over |=> high_process_alarm_q[N_IN-1]; endproperty
  a_in_set: assert property (p_in_set) else $error("alarm unset");
  property p_in_keep; high_process_alarm_q[N_IN-1] && in_band
    |=> high_process_alarm_q[N_IN-1]; endproperty
  a_in_keep: assert property (p_in_keep) else $error("alarm lost");
  // slewing moves only on update ticks, never on two edges in a row
  property p_slew; in_run && $past(in_run) && out_cfg.run_slew_enable
    && $past(out_cfg.run_slew_enable) && $changed(out_value_q)
    |=> $stable(out_value_q); endproperty
  a_slew: assert property (p_slew) else $error("slew too fast");
endmodule : aoc_props
bind aoc_channel aoc_props #(.N_IN(N_IN), .UPDATE_NS(UPDATE_NS)) u_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .comm_ok(comm_ok), .run_mode(run_mode),
  .out_cfg(out_cfg), .requested_value(requested_value),
  .alarm_clear(alarm_clear), .in_cfg(in_cfg), .in_value(in_value),
  .out_value_q(out_value_q), .out_range_q(out_range_q),
  .out_alarm_q(out_alarm_q), .state_q(state_q),
  .high_process_alarm_q(high_process_alarm_q));
`default_nettype wire
